//--- logic/adc_irq_consts.svh
// Offsets, field positions and reset values for the ADC interrupt enable block
`ifndef ADC_IRQ_CONSTS_SVH
`define ADC_IRQ_CONSTS_SVH
`define IRQ_MASK_SET_OFS 12'h304
`define IRQ_MASK_CLEAR_OFS 12'h308
`define IRQ_PEND_OFS 12'h30C
`define IRQ_RAISE_OFS 12'h310
`define IRQ_EN_RESET 22'h00_0000
`define IRQ_NUM_EVENTS 22
`define IRQ_NUM_CHANNELS 8
`define BIT_CONVERSION_BEGUN 0
`define BIT_BUFFER_END 1
`define BIT_SAMPLE_DONE 2
`define BIT_RESULT_WRITTEN 3
`define BIT_OFFSET_TRIM_FINISHED 4
`define BIT_HALT_COMPLETE 5
`define BIT_CHAN0_HIGH_LIMIT 6
`define BIT_CHAN0_LOW_LIMIT 7
`define BIT_CHAN7_HIGH_LIMIT 20
`define BIT_CHAN7_LOW_LIMIT 21
`endif

//--- logic/adc_irq_pkg.sv
// Types for the ADC interrupt enable block
package adc_irq_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage : adc_irq_pkg

//--- logic/adc_interrupt_enable_set_clear.sv
// Interrupt enable set/clear register pair with sticky event status
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "adc_irq_consts.svh"
// What this block does
// - Writing one to a clear register bit disables it; reads return enables.
// - Writing one to a set register bit enables it; reset to zero.
// - Bits 0 to 5: begun, buffer end, sample, result, trim, halt.
// - Bit 6 is channel 0 high limit in both registers.
// - Bits 20 and 21 are channel 7 high and low; above unused.
// - Bits 7 to 19 alternate low/high limits of channels 0 to 6.
module adc_interrupt_enable_set_clear
  import adc_irq_pkg::*;
#(
  parameter int NUM_EVENTS = `IRQ_NUM_EVENTS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Event pulses from the converter, same clock
  input wire logic [NUM_EVENTS-1:0] event_pulse,
  // Interrupt
  output logic irq
);


  // Event layout: six converter events, then two limit events per channel
  localparam int NUM_CHANNELS = `IRQ_NUM_CHANNELS;
  localparam int NUM_CORE = `BIT_CHAN0_HIGH_LIMIT;
  localparam int LIMIT_BASE = `BIT_CHAN0_HIGH_LIMIT;
  localparam int RDATA_W = 32;

  // Register select helper, shared by every address decode
  function automatic logic addr_hit
  (
    input logic [11:0] addr,
    input logic [11:0] ofs
  );
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  // Write-one helper: the data bits that a strobed write acts on
  function automatic logic [NUM_EVENTS-1:0] w1_mask
  (
    input logic strobe,
    input logic [NUM_EVENTS-1:0] data
  );
    w1_mask = strobe ? data : '0;
  endfunction : w1_mask

  // Request bundle
  reg_req_type req;

  // Decoded selects and write strobes
  wire logic sel_set;
  wire logic sel_clr;
  wire logic sel_pend;
  wire logic wr_set;
  wire logic wr_clr;
  wire logic wr_pend;

  // Write data cut to the used event bits
  wire logic [NUM_EVENTS-1:0] wbits;

  // Per-register write-one masks
  wire logic [NUM_EVENTS-1:0] set_mask;
  wire logic [NUM_EVENTS-1:0] clr_mask;
  wire logic [NUM_EVENTS-1:0] pend_clr_mask;

  // Enable flags, one shared set behind both registers
  logic [NUM_EVENTS-1:0] enable_ff;
  wire logic [NUM_EVENTS-1:0] nxt_enable;

  // Sticky event status
  logic [NUM_EVENTS-1:0] pend_ff;
  wire logic [NUM_EVENTS-1:0] nxt_pend;

  // Named views of the enable flags
  wire logic [NUM_CORE-1:0] core_en;
  wire logic [NUM_CHANNELS-1:0] chan_high_en;
  wire logic [NUM_CHANNELS-1:0] chan_low_en;
  wire logic [NUM_EVENTS-1:0] enable_view;

  // Read path
  logic [RDATA_W-1:0] rdata_ff;
  wire logic [RDATA_W-1:0] nxt_rdata;
  wire logic [RDATA_W-1:0] enable_word;
  wire logic [RDATA_W-1:0] pend_word;

  // Interrupt
  logic irq_ff;
  wire logic nxt_irq;

  // Bundle the plain register port
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Bits above the last event are ignored on write
  assign wbits = req.wdata[NUM_EVENTS-1:0];

  // Address decode; the master never drives both strobes at once
  assign sel_set = addr_hit(req.addr, `IRQ_MASK_SET_OFS);
  assign sel_clr = addr_hit(req.addr, `IRQ_MASK_CLEAR_OFS);
  assign sel_pend = addr_hit(req.addr, `IRQ_PEND_OFS);
  assign wr_set = req.wr && sel_set;
  assign wr_clr = req.wr && sel_clr;
  assign wr_pend = req.wr && sel_pend;

  // Only the ones of a write act; zeros leave the flags alone
  assign set_mask = w1_mask(wr_set, wbits);
  assign clr_mask = w1_mask(wr_clr, wbits);
  assign pend_clr_mask = w1_mask(wr_pend, wbits);

  // Per-event next state
  genvar b;
  generate
    for (b = 0; b < NUM_EVENTS; b++)
    begin : g_bit
      // Set and clear hit different offsets, so they never meet in one cycle
      assign nxt_enable[b] = set_mask[b] | (enable_ff[b] & ~clr_mask[b]);
      // A new event wins over a clear in the same cycle
      assign nxt_pend[b] = event_pulse[b] | (pend_ff[b] & ~pend_clr_mask[b]);
    end
  endgenerate

  // Converter events occupy the lowest six bits, in order
  assign core_en[`BIT_CONVERSION_BEGUN] = enable_ff[`BIT_CONVERSION_BEGUN];
  assign core_en[`BIT_BUFFER_END] = enable_ff[`BIT_BUFFER_END];
  assign core_en[`BIT_SAMPLE_DONE] = enable_ff[`BIT_SAMPLE_DONE];
  assign core_en[`BIT_RESULT_WRITTEN] = enable_ff[`BIT_RESULT_WRITTEN];
  assign core_en[`BIT_OFFSET_TRIM_FINISHED] = enable_ff[`BIT_OFFSET_TRIM_FINISHED];
  assign core_en[`BIT_HALT_COMPLETE] = enable_ff[`BIT_HALT_COMPLETE];
  assign enable_view[NUM_CORE-1:0] = core_en;

  // Limit events: channel ch high at base plus 2ch, low just above it
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++)
    begin : g_chan
      // Channel 0 high is bit 6, channel 7 low is bit 21, the top used bit
      assign chan_high_en[ch] = enable_ff[LIMIT_BASE + 2 * ch];
      assign chan_low_en[ch] = enable_ff[LIMIT_BASE + 2 * ch + 1];
      assign enable_view[LIMIT_BASE + 2 * ch] = chan_high_en[ch];
      assign enable_view[LIMIT_BASE + 2 * ch + 1] = chan_low_en[ch];
    end
  endgenerate

  // Read words; unused upper bits read as zero
  assign enable_word = RDATA_W'(enable_view);
  assign pend_word = RDATA_W'(pend_ff);

  // Read mux; both enable registers show the same flags
  assign nxt_rdata = !req.rd ? 32'h0000_0000
                   : (sel_set || sel_clr) ? enable_word
                   : sel_pend ? pend_word
                   : 32'h0000_0000;

  // Level interrupt from enabled status, taken from next state
  assign nxt_irq = |(nxt_pend & nxt_enable);

  // Enable flags
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      enable_ff <= NUM_EVENTS'(`IRQ_EN_RESET);
    end
    else
    begin
      enable_ff <= nxt_enable;
    end
  end

  // Sticky status
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pend_ff <= '0;
    end
    else
    begin
      pend_ff <= nxt_pend;
    end
  end

  // Read data, valid only in the cycle after a read strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Interrupt flop, so the pin comes straight from a register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end

  // Outputs
  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;

  // Limitation: the channel map assumes the default event count
  // Limitation: a write to an unmapped offset is dropped silently
  // Hazard avoided: the status clear cannot swallow an event in flight
  // Trade: read data costs one flop stage but keeps the read path short
  // Trade: the interrupt uses next state so it rises one cycle sooner
  // Note: the offsets of the status and set registers are local choices
  // Note: the spare offset above the status register reads as zero
  // Note: reset is synchronous and held at least one clock edge
  // Note: the converter and limit logic drive event_pulse on this clock
  // Note: every event pulse is one cycle long
  // Note: no wait states are ever inserted on the register port
  // Note: read and write strobes are never high in the same cycle
  // Note: enables and status share one bit layout
  // Note: bits 22 to 31 of every register read as zero
  // Note: the set register and the clear register read back alike
  // Note: an event that is disabled still sets its status bit
  // Note: enabling a pending event raises the interrupt at once
  // Note: clearing an enable drops the interrupt at once
  // Note: the interrupt is a level, not a pulse
  // Note: software clears status by writing ones to it

endmodule : adc_interrupt_enable_set_clear
`default_nettype wire

//--- tb/adc_irq_sva.sv
// Checker for the interrupt enable set/clear pair
`timescale 1ns/100ps
`default_nettype none
module adc_irq_sva (
  input wire logic clk, rst_n, reg_wr, reg_rd, irq,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rz; !reg_rd |=> reg_rdata == 0; endproperty
  a_rz: assert property (p_rz) else $error("stray data");
  property p_hi; reg_rd |=> reg_rdata[31:22] == 0; endproperty
  a_hi: assert property (p_hi) else $error("high bits");
  property p_set; reg_wr && reg_addr == 12'h304 && reg_wdata[6] ##1 reg_rd
    && reg_addr == 12'h308 |=> reg_rdata[6]; endproperty
  a_set: assert property (p_set) else $error("set lost");
  property p_clr; reg_wr && reg_addr == 12'h308 && reg_wdata[0] ##1 reg_rd
    && reg_addr == 12'h304 |=> !reg_rdata[0]; endproperty
  a_clr: assert property (p_clr) else $error("clear lost");
  property p_off; reg_wr && reg_addr == 12'h308 && &reg_wdata ##1 !reg_wr
    |=> !irq; endproperty
  a_off: assert property (p_off) else $error("irq stuck");
  property p_clr7; reg_wr && reg_addr == 12'h308 && reg_wdata[21] ##1 reg_rd
    && reg_addr == 12'h304 |=> !reg_rdata[21]; endproperty
  a_clr7: assert property (p_clr7) else $error("top clear lost");
endmodule : adc_irq_sva
bind adc_interrupt_enable_set_clear adc_irq_sva adc_irq_sva_inst (.*);
`default_nettype wire

//--- tb/tb_adc_interrupt_enable_set_clear.sv
// Bench for the interrupt enable set/clear pair
`timescale 1ns/100ps
`default_nettype none
module tb_adc_interrupt_enable_set_clear;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, irq;
  logic [11:0] a = 0;
  logic [31:0] d = 0, q, r;
  logic [21:0] ev = 0;
  int n_errors = 0, check_count = 0, seed = 89368, en = 0, i;
  adc_interrupt_enable_set_clear adc_interrupt_enable_set_clear_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(a), .reg_wdata(d), .reg_wr(wr), .reg_rd(rd), .reg_rdata(q),
    .event_pulse(ev), .irq(irq));
  initial forever #50 clk = ~clk;
  // Compare seen against expected
  task chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // One strobe cycle, read data settled on return
  task cyc(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    wr <= w; rd <= !w; a <= ad; d <= wd;
    @(posedge clk);
    wr <= 0; rd <= 0;
    #1;
  endtask : cyc
  // Counts and verdict
  task results;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Random set and clear writes against the model
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    cyc(0, 12'h304, 0); chk("reset enables", q, 0);
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed) | (i[0] ? 32'h1 : 32'h40);
      cyc(1, i[0] ? 12'h308 : 12'h304, r);
      en = (i[0] ? en & ~r : en | r) & 32'h003F_FFFF;
      cyc(0, i[1] ? 12'h308 : 12'h304, 0); chk("enables", q, en);
    end
    cyc(0, 12'h310, 0); chk("spare offset", q, 0);
    cyc(1, 12'h304, 32'h0020_0000);
    ev <= 22'h20_0000; @(posedge clk); ev <= 0; #1 chk("irq raised", irq, 1);
    cyc(1, 12'h30C, 32'h0020_0000); @(posedge clk); #1 chk("irq cleared", irq, 0);
    cyc(1, 12'h308, 32'hFFFF_FFFF); cyc(0, 12'h304, 0); chk("all cleared", q, 0);
    repeat (3) @(posedge clk);
    results();
  end
endmodule : tb_adc_interrupt_enable_set_clear
`default_nettype wire
